// *** core/gpt_map.svh ***
// Register offsets, field positions, codes and reset values of the timer.
// Included by the timer top; definitions only.
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH

`define GPT_A_CTRL 8'h00
`define GPT_A_SMC 8'h04
`define GPT_A_EVG 8'h08
`define GPT_A_STAT 8'h0C
`define GPT_A_CNT 8'h10
`define GPT_A_PRESC 8'h14
`define GPT_A_RLD 8'h18
`define GPT_A_CHCFG 8'h1C
`define GPT_A_CCR1 8'h20
`define GPT_A_CCR2 8'h24
`define GPT_A_DT 8'h28

`define GPT_F_EN 0
`define GPT_F_SMODE 2:0
`define GPT_F_TSEL 6:4
`define GPT_F_UPD 0
`define GPT_F_CFG1 13:0
`define GPT_F_CFG2 29:16
`define GPT_F_FLAG 1:0
`define GPT_F_OVF 3:2
`define GPT_F_UIF 4
`define GPT_F_DT 7:0
`define GPT_F_CNT 15:0

`define GPT_SMODE_INT 3'h0
`define GPT_SMODE_EXT1 3'h7
`define GPT_TSEL_ED 3'h4
`define GPT_TSEL_CH1 3'h5
`define GPT_TSEL_CH2 3'h6

`define GPT_SEL_OUT 2'h0
`define GPT_SEL_CROSS 2'h2

`define GPT_OCM_ACT 3'h1
`define GPT_OCM_INACT 3'h2
`define GPT_OCM_TOG 3'h3
`define GPT_OCM_FLO 3'h4
`define GPT_OCM_FHI 3'h5
`define GPT_OCM_PWM1 3'h6
`define GPT_OCM_PWM2 3'h7

`define GPT_RST_RLD 16'hFFFF

`endif

// *** core/gpt_pkg.sv ***
// Types shared by the timer modules: counter word, channel setup, states.
// Assumes nothing beyond a SystemVerilog compiler.
package gpt_pkg;
   typedef logic [15:0] gpt_cnt_t;
   typedef struct packed {
      logic [2:0] ocm;
      logic cpol;
      logic npol;
      logic [1:0] div;
      logic pol;
      logic [3:0] filt;
      logic [1:0] sel;
   } gpt_chcfg_s;
   typedef struct packed {
      logic [2:0] sy;
      logic lvl;
      logic [3:0] fc;
      logic filt;
      logic rise;
      logic fall;
   } gpt_cin_s;
   typedef struct packed {
      logic oref_d;
      logic [7:0] cnt;
      logic om;
      logic on;
   } gpt_dt_s;
   typedef struct packed {
      logic en;
      logic [2:0] smode;
      logic [2:0] tsel;
      gpt_cnt_t cnt;
      gpt_cnt_t presc;
      gpt_cnt_t presc_act;
      gpt_cnt_t presc_cnt;
      gpt_cnt_t reload;
      gpt_chcfg_s [1:0] cfg;
      gpt_cnt_t [1:0] pre;
      gpt_cnt_t [1:0] shd;
      logic [1:0] cp_pend;
      logic [1:0][2:0] dvc;
      logic [1:0] flag;
      logic [1:0] ovf;
      logic uif;
      logic [1:0] oref;
      logic [7:0] dt;
      logic trig_d;
      logic [31:0] prdata;
      logic perr;
   } gpt_top_s;
endpackage

// *** core/gpt_ch_if.sv ***
// Per-channel signals between the timer core, input path and output stage.
// Inputs driven by the timer top, outputs by the channel modules, all through continuous assignments.
`timescale 1ns/1ps
interface gpt_ch_if;
   logic pin;
   logic [3:0] filt_set;
   logic filt;
   logic rise;
   logic fall;
   logic oref;
   logic [7:0] dt;
   logic cpol;
   logic npol;
   logic out_m;
   logic out_n;
   modport inp (input pin, filt_set, output filt, rise, fall);
   modport dtg (input oref, dt, cpol, npol, output out_m, out_n);
endinterface

// *** core/gpt_chan_in.sv ***
// Channel input path: pin synchroniser, digital filter, edge detector.
// Pin is asynchronous to mclk; filter setting comes from the core.
`timescale 1ns/1ps
module gpt_chan_in (
   input wire logic mclk,
   input wire logic reset,
   gpt_ch_if.inp ch
);
   import gpt_pkg::*;
   gpt_cin_s r;
   gpt_cin_s n;

   always_comb begin
      n = r;
      n.sy = {r.sy[1:0], ch.pin};
      // Only the second and third stages are compared
      if (r.sy[1] == r.sy[2]) begin
         n.lvl = r.sy[2];
      end
      // New level must persist past the setting before it passes
      if (r.lvl == r.filt) begin
         n.fc = 4'h0;
      end else if (r.fc >= ch.filt_set) begin
         n.filt = r.lvl;
         n.fc = 4'h0;
      end else begin
         n.fc = r.fc + 4'h1;
      end
      n.rise = n.filt & ~r.filt;
      n.fall = ~n.filt & r.filt;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign ch.filt = r.filt;
   assign ch.rise = r.rise;
   assign ch.fall = r.fall;

   property p_filt;
      @(posedge mclk) disable iff (reset)
      r.lvl != r.filt && r.fc < ch.filt_set |=> r.filt == $past(r.filt);
   endproperty
   a_filt: assert property (p_filt)
      else $error("filter passed a level too early");
endmodule // gpt_chan_in

// *** core/gpt_dtgen.sv ***
// Channel output stage: complementary pair with dead time and polarity.
// Dead time counts mclk cycles; reference comes from the core.
`timescale 1ns/1ps
module gpt_dtgen (
   input wire logic mclk,
   input wire logic reset,
   gpt_ch_if.dtg ch
);
   import gpt_pkg::*;
   gpt_dt_s r;
   gpt_dt_s n;
   logic idle;

   always_comb begin
      n = r;
      n.oref_d = ch.oref;
      // Both legs rest while the gap runs, so they never overlap
      if (ch.oref != r.oref_d) begin
         n.cnt = ch.dt;
      end else if (r.cnt != 8'h00) begin
         n.cnt = r.cnt - 8'h01;
      end
      idle = n.cnt != 8'h00;
      n.om = (ch.oref & ~idle) ^ ch.cpol;
      n.on = (~ch.oref & ~idle) ^ ch.npol;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign ch.out_m = r.om;
   assign ch.out_n = r.on;

   property p_dead;
      @(posedge mclk) disable iff (reset)
      ch.oref != r.oref_d && ch.dt != 8'h00 |=>
         r.om == $past(ch.cpol) && r.on == $past(ch.npol);
   endproperty
   a_dead: assert property (p_dead)
      else $error("outputs not idle during dead time");
endmodule // gpt_dtgen

// *** core/gpt_top.sv ***
// Sixteen-bit up-counting timer with prescaler, reload, two channels.
// APB slave on mclk; channel pins asynchronous; triggers on mclk.
//
// How it works
// - Sixteen-bit up counter reloaded each cycle
// - No down or centre counting
// - Prescaler divides by value plus one
// - New prescale value waits for update event
// - Counter restarts from zero after reaching reload value register
// - Slave mode zero counts internal bus clock
// - Slave mode seven counts rising edges of the trigger
// - Trigger from internal triggers or channels
// - No external clock pin exists
// - Two channels, each capture or compare
// - Input filtered, edge detected, polarity selected
// - Own or neighbour input, then event divider
// - Software accesses only the preload copy
// - Capture latches shadow, then copies preload
// - Compare uses shadow loaded from preload
// - Complementary outputs separated by dead time
// - Independent polarity for each output leg
// - Capture sets flag, overcapture; CCR read clears flag only
// - Modes four, five force reference output
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "gpt_map.svh"
module gpt_top (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] internal_trigger_in,
   input wire logic [1:0] ch_pin_in,
   output logic [1:0] ch_pin_out,
   output logic [1:0] ch_pin_oe,
   output logic [1:0] ch_n_out
);
   import gpt_pkg::*;
   gpt_top_s r;
   gpt_top_s n;
   logic setup;
   logic acc_wr;
   logic acc_rd;
   logic upd_req;
   logic trig;
   logic in_tick;
   logic cnt_tick;
   logic wrap;
   logic uev;
   logic [1:0] filt;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] capm;
   logic [1:0] evt;
   logic [1:0] cap;
   logic [1:0] mtch;
   logic [1:0] rdclr;
   logic [1:0][2:0] lim;

   assign setup = psel & ~penable;
   assign acc_wr = psel & penable & pwrite;
   assign acc_rd = psel & penable & ~pwrite;
   assign upd_req = acc_wr & (paddr == `GPT_A_EVG) & pwdata[`GPT_F_UPD];

   // Only internal triggers and channels reach the trigger
   always_comb begin
      case (r.tsel)
         `GPT_TSEL_ED: trig = rise[0] | fall[0];
         `GPT_TSEL_CH1: trig = filt[0] ^ r.cfg[0].pol;
         `GPT_TSEL_CH2: trig = filt[1] ^ r.cfg[1].pol;
         default: trig = ~r.tsel[2] & internal_trigger_in[r.tsel[1:0]];
      endcase
   end

   // Unlisted slave modes fall back to the bus clock
   assign in_tick = r.en & ((r.smode != `GPT_SMODE_EXT1) | (trig & ~r.trig_d));
   assign cnt_tick = in_tick & (r.presc_cnt == r.presc_act);
   assign wrap = cnt_tick & (r.cnt == r.reload);
   assign uev = upd_req | wrap;

   always_comb begin
      n = r;
      capm = '0;
      evt = '0;
      cap = '0;
      mtch = '0;
      rdclr = '0;
      lim = '0;
      n.trig_d = trig;
      if (in_tick) begin
         n.presc_cnt = cnt_tick ? 16'h0000 : r.presc_cnt + 16'h0001;
      end
      // Up only; the reload value closes each cycle
      if (cnt_tick) begin
         n.cnt = wrap ? 16'h0000 : r.cnt + 16'h0001;
      end
      if (upd_req) begin
         n.cnt = 16'h0000;
         n.presc_cnt = 16'h0000;
      end
      if (acc_wr) begin
         if (paddr == `GPT_A_CTRL) begin
            n.en = pwdata[`GPT_F_EN];
         end else if (paddr == `GPT_A_SMC) begin
            n.smode = pwdata[`GPT_F_SMODE];
            n.tsel = pwdata[`GPT_F_TSEL];
         end else if (paddr == `GPT_A_STAT) begin
            n.flag = r.flag & ~pwdata[`GPT_F_FLAG];
            n.ovf = r.ovf & ~pwdata[`GPT_F_OVF];
            n.uif = r.uif & ~pwdata[`GPT_F_UIF];
         end else if (paddr == `GPT_A_CNT) begin
            n.cnt = pwdata[`GPT_F_CNT];
         end else if (paddr == `GPT_A_PRESC) begin
            n.presc = pwdata[`GPT_F_CNT];
         end else if (paddr == `GPT_A_RLD) begin
            n.reload = pwdata[`GPT_F_CNT];
         end else if (paddr == `GPT_A_CHCFG) begin
            n.cfg[0] = pwdata[`GPT_F_CFG1];
            n.cfg[1] = pwdata[`GPT_F_CFG2];
         end else if (paddr == `GPT_A_CCR1) begin
            n.pre[0] = pwdata[`GPT_F_CNT];
         end else if (paddr == `GPT_A_CCR2) begin
            n.pre[1] = pwdata[`GPT_F_CNT];
         end else if (paddr == `GPT_A_DT) begin
            n.dt = pwdata[`GPT_F_DT];
         end
      end
      // Prescale value moves to the divider only here
      if (uev) begin
         n.presc_act = r.presc;
         n.uif = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
         capm[i] = r.cfg[i].sel != `GPT_SEL_OUT;
         // Neighbour's filtered input under own polarity
         if (r.cfg[i].sel == `GPT_SEL_CROSS) begin
            evt[i] = r.cfg[i].pol ? fall[1 - i] : rise[1 - i];
         end else begin
            evt[i] = r.cfg[i].pol ? fall[i] : rise[i];
         end
         evt[i] = evt[i] & capm[i];
         lim[i] = 3'((4'h1 << r.cfg[i].div) - 4'h1);
         if (evt[i]) begin
            n.dvc[i] = (r.dvc[i] == lim[i]) ? 3'h0 : r.dvc[i] + 3'h1;
         end
         cap[i] = evt[i] & (r.dvc[i] == lim[i]);
         // Capture hits the shadow first, preload a cycle later
         if (r.cp_pend[i]) begin
            n.pre[i] = r.shd[i];
         end
         n.cp_pend[i] = cap[i];
         if (cap[i]) begin
            n.shd[i] = r.cnt;
         end else if (!capm[i] && (uev || !r.en)) begin
            n.shd[i] = r.pre[i];
         end
         mtch[i] = !capm[i] & cnt_tick & (n.cnt == r.shd[i]);
         rdclr[i] = acc_rd & (paddr == (i == 0 ? `GPT_A_CCR1 : `GPT_A_CCR2));
         if (rdclr[i]) begin
            n.flag[i] = 1'b0;
         end
         // Set after clear: an event in the clearing cycle survives
         if (cap[i] | mtch[i]) begin
            n.flag[i] = 1'b1;
         end
         if (cap[i] & r.flag[i]) begin
            n.ovf[i] = 1'b1;
         end
         case (r.cfg[i].ocm)
            `GPT_OCM_ACT: if (mtch[i]) n.oref[i] = 1'b1;
            `GPT_OCM_INACT: if (mtch[i]) n.oref[i] = 1'b0;
            `GPT_OCM_TOG: if (mtch[i]) n.oref[i] = ~r.oref[i];
            `GPT_OCM_FLO: n.oref[i] = 1'b0;
            `GPT_OCM_FHI: n.oref[i] = 1'b1;
            `GPT_OCM_PWM1: n.oref[i] = n.cnt < r.shd[i];
            `GPT_OCM_PWM2: n.oref[i] = !(n.cnt < r.shd[i]);
            default: n.oref[i] = r.oref[i];
         endcase
      end
      // Read data is taken in the setup cycle so it leaves a flop
      if (setup) begin
         n.perr = 1'b0;
         if (paddr == `GPT_A_CTRL) begin
            n.prdata = {31'h0, r.en};
         end else if (paddr == `GPT_A_SMC) begin
            n.prdata = {25'h0, r.tsel, 1'b0, r.smode};
         end else if (paddr == `GPT_A_EVG) begin
            n.prdata = 32'h0;
         end else if (paddr == `GPT_A_STAT) begin
            n.prdata = {27'h0, r.uif, r.ovf, r.flag};
         end else if (paddr == `GPT_A_CNT) begin
            n.prdata = {16'h0, r.cnt};
         end else if (paddr == `GPT_A_PRESC) begin
            n.prdata = {16'h0, r.presc};
         end else if (paddr == `GPT_A_RLD) begin
            n.prdata = {16'h0, r.reload};
         end else if (paddr == `GPT_A_CHCFG) begin
            n.prdata = {2'h0, r.cfg[1], 2'h0, r.cfg[0]};
         end else if (paddr == `GPT_A_CCR1) begin
            n.prdata = {16'h0, r.pre[0]};
         end else if (paddr == `GPT_A_CCR2) begin
            n.prdata = {16'h0, r.pre[1]};
         end else if (paddr == `GPT_A_DT) begin
            n.prdata = {24'h0, r.dt};
         end else begin
            n.prdata = 32'h0;
            n.perr = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         r <= '0;
         r.reload <= `GPT_RST_RLD;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = 1'b1;
   assign pslverr = r.perr;

   for (genvar g = 0; g < 2; g++) begin : g_ch
      gpt_ch_if chif();
      assign chif.pin = ch_pin_in[g];
      assign chif.filt_set = r.cfg[g].filt;
      assign chif.oref = r.oref[g];
      assign chif.dt = r.dt;
      assign chif.cpol = r.cfg[g].cpol;
      assign chif.npol = r.cfg[g].npol;
      assign filt[g] = chif.filt;
      assign rise[g] = chif.rise;
      assign fall[g] = chif.fall;
      assign ch_pin_out[g] = chif.out_m;
      assign ch_n_out[g] = chif.out_n;
      assign ch_pin_oe[g] = r.cfg[g].sel == `GPT_SEL_OUT;
      gpt_chan_in u_in (
         .mclk(mclk),
         .reset(reset),
         .ch(chif.inp)
      );
      gpt_dtgen u_dt (
         .mclk(mclk),
         .reset(reset),
         .ch(chif.dtg)
      );
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   property p_wrap;
      wrap && !acc_wr |=> r.cnt == 16'h0000 && r.uif;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("counter did not wrap at reload");

   property p_up;
      cnt_tick && !wrap && !upd_req && !acc_wr |=>
         r.cnt == $past(r.cnt) + 16'h0001;
   endproperty
   a_up: assert property (p_up)
      else $error("counter did not step up by one");

   sequence s_div2;
      cnt_tick && !uev && r.presc_act == 16'h0001 &&
      r.smode == `GPT_SMODE_INT
      ##1 (r.en && !upd_req && r.smode == `GPT_SMODE_INT) [*2];
   endsequence
   property p_div;
      s_div2 |-> cnt_tick && !$past(cnt_tick);
   endproperty
   a_div: assert property (p_div)
      else $error("prescaler did not divide by two");

   property p_presc;
      !uev |=> r.presc_act == $past(r.presc_act);
   endproperty
   a_presc: assert property (p_presc)
      else $error("prescaler changed without update");

   property p_ext;
      (r.smode == `GPT_SMODE_EXT1 && !upd_req && !acc_wr && !trig) [*2] |=>
         r.cnt == $past(r.cnt);
   endproperty
   a_ext: assert property (p_ext)
      else $error("counted with no trigger edge");

   sequence s_copy0;
      r.shd[0] == $past(r.cnt) ##1 r.pre[0] == $past(r.shd[0]);
   endsequence
   property p_cap;
      cap[0] |=> s_copy0;
   endproperty
   a_cap: assert property (p_cap)
      else $error("capture did not reach shadow and preload");

   property p_cmp;
      !capm[0] && uev |=> r.shd[0] == $past(r.pre[0]);
   endproperty
   a_cmp: assert property (p_cmp)
      else $error("shadow not loaded from preload");

   property p_ovc;
      cap[1] && r.flag[1] |=> r.ovf[1] && r.flag[1];
   endproperty
   a_ovc: assert property (p_ovc)
      else $error("overcapture not flagged");

   property p_force;
      r.cfg[0].ocm == `GPT_OCM_FLO && mtch[0] |=> !r.oref[0] && r.flag[0];
   endproperty
   a_force: assert property (p_force)
      else $error("forced low lost level or flag");
endmodule // gpt_top

// *** verification/gpt_far_model.sv ***
// Far side of the timer: other timers' trigger lines and channel pin drivers.
// Assumes the bench resolves each channel pin from the timer's enables.
`timescale 1ns/1ps
module gpt_far_model (
   input wire logic mclk,
   output logic [3:0] trig,
   output logic [1:0] pin_drv
);
   initial begin
      trig = 4'h0;
      pin_drv = 2'h0;
   end

   // Two cycles high, three low before the next: each pulse is one clean rising edge
   task automatic trig_pulses(input int line, input int n);
      repeat (n) begin
         @(posedge mclk);
         trig[line] <= 1'b1;
         repeat (2) @(posedge mclk);
         trig[line] <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask

   // Holds long enough for synchroniser and filter to settle
   task automatic pin_set(input int ch, input logic v);
      @(posedge mclk);
      pin_drv[ch] <= v;
      repeat (12) @(posedge mclk);
   endtask
endmodule // gpt_far_model

// *** verification/tb.sv ***
// Self-checking bench for the timer: APB tasks, triggers, pins, outputs.
// Assumes the far-side model and the timer's register map header.
`timescale 1ns/1ps
`include "gpt_map.svh"
`define CHK(what, exp, got) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("[ERR] %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module tb;
   import gpt_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] trig;
   logic [1:0] pin_drv;
   logic [1:0] ch_pin_in;
   logic [1:0] ch_pin_out;
   logic [1:0] ch_pin_oe;
   logic [1:0] ch_n_out;
   int err_count = 0;
   int checks_done = 0;

   always #2 mclk = ~mclk;
   // Pin level: timer drives while enabled, far side otherwise
   assign ch_pin_in = (ch_pin_oe & ch_pin_out) | (~ch_pin_oe & pin_drv);

   gpt_top uut (.mclk(mclk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .internal_trigger_in(trig), .ch_pin_in(ch_pin_in),
      .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe), .ch_n_out(ch_n_out));
   gpt_far_model far (.mclk(mclk), .trig(trig), .pin_drv(pin_drv));

   task automatic report_and_stop;
      if (err_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 100) begin
         n++;
         @(posedge mclk);
      end
      if (n == 100) begin
         err_count++;
         report_and_stop();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a,
         input logic [31:0] exp);
      logic [31:0] d;
      logic e;
      apb(1'b0, a, 32'h0, d, e);
      `CHK(what, exp, d)
   endtask

   initial begin
      repeat (50000) @(posedge mclk);
      err_count++;
      report_and_stop();
   end

   initial begin
      logic [31:0] r1;
      logic [31:0] r2;
      logic er;
      logic [1:0] pair;
      logic [31:0] ocfg [4];
      logic [1:0] oexp [4];
      ocfg = '{32'h2800, 32'h2000, 32'h2E00, 32'h2400};
      oexp = '{2'b10, 2'b01, 2'b01, 2'b11};
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      rd_chk("reload", `GPT_A_RLD, 32'h0000FFFF);
      rd_chk("count", `GPT_A_CNT, 32'h0);
      `CHK("pin enables", 2'b11, ch_pin_oe)
      apb(1'b0, 8'hFC, 32'h0, r1, er);
      `CHK("unmapped err", 1'b1, er)
      // Trigger clocking, divide by three, reload at four
      wr(`GPT_A_SMC, 32'h7);
      wr(`GPT_A_RLD, 32'h4);
      wr(`GPT_A_PRESC, 32'h2);
      wr(`GPT_A_EVG, 32'h1);
      wr(`GPT_A_STAT, 32'h1F);
      wr(`GPT_A_CTRL, 32'h1);
      far.trig_pulses(0, 18);
      rd_chk("wrapped count", `GPT_A_CNT, 32'h1);
      // Wrap to zero also matches both idle shadows
      rd_chk("update flag", `GPT_A_STAT, 32'h13);
      // New prescale waits for an update event
      wr(`GPT_A_PRESC, 32'h0);
      far.trig_pulses(0, 3);
      rd_chk("old divider", `GPT_A_CNT, 32'h2);
      wr(`GPT_A_EVG, 32'h1);
      far.trig_pulses(0, 3);
      rd_chk("new divider", `GPT_A_CNT, 32'h3);
      for (int t = 1; t < 4; t++) begin
         wr(`GPT_A_SMC, 32'h7 | (t << 4));
         wr(`GPT_A_EVG, 32'h1);
         far.trig_pulses(t, 2);
         rd_chk("trigger line", `GPT_A_CNT, 32'h2);
      end
      // Internal clock: three bus cycles between read setups
      wr(`GPT_A_RLD, 32'hFFFF);
      wr(`GPT_A_SMC, 32'h0);
      wr(`GPT_A_EVG, 32'h1);
      apb(1'b0, `GPT_A_CNT, 32'h0, r1, er);
      apb(1'b0, `GPT_A_CNT, 32'h0, r2, er);
      `CHK("bus clock steps", 32'h3, r2 - r1)
      // Divide by two; the update fixes the phase
      wr(`GPT_A_PRESC, 32'h1);
      wr(`GPT_A_EVG, 32'h1);
      apb(1'b0, `GPT_A_CNT, 32'h0, r1, er);
      apb(1'b0, `GPT_A_CNT, 32'h0, r2, er);
      `CHK("divided steps", 32'h2, r2 - r1)
      wr(`GPT_A_PRESC, 32'h0);
      wr(`GPT_A_CTRL, 32'h0);
      // Capture: ch1 own pin, ch2 neighbour pin dividing by two
      wr(`GPT_A_CNT, 32'h1234);
      wr(`GPT_A_CHCFG, 32'h00820001);
      repeat (8) @(posedge mclk);
      `CHK("input pins", 2'b00, ch_pin_oe)
      wr(`GPT_A_STAT, 32'h1F);
      // Four rises: both channels overcapture
      repeat (4) begin
         far.pin_set(0, 1'b1);
         far.pin_set(0, 1'b0);
      end
      rd_chk("capture flags", `GPT_A_STAT, 32'hF);
      rd_chk("ch1 capture", `GPT_A_CCR1, 32'h1234);
      rd_chk("flag cleared", `GPT_A_STAT, 32'hE);
      rd_chk("ch2 capture", `GPT_A_CCR2, 32'h1234);
      // Falling-edge polarity and a five-cycle filter on ch1
      wr(`GPT_A_CHCFG, 32'h00000051);
      wr(`GPT_A_CNT, 32'h0055);
      wr(`GPT_A_STAT, 32'h1F);
      far.pin_set(0, 1'b1);
      rd_chk("no rise capture", `GPT_A_STAT, 32'h0);
      far.pin_set(0, 1'b0);
      rd_chk("fall capture", `GPT_A_STAT, 32'h1);
      rd_chk("fall value", `GPT_A_CCR1, 32'h0055);
      // Forced levels, polarity, dead time on ch1
      wr(`GPT_A_DT, 32'h8);
      for (int i = 0; i < 4; i++) begin
         wr(`GPT_A_CHCFG, ocfg[i]);
         if (i == 1) begin
            repeat (3) @(posedge mclk);
            `CHK("dead time gap", 1'b0, ch_n_out[0])
         end
         repeat (16) @(posedge mclk);
         pair = {ch_pin_out[0], ch_n_out[0]};
         `CHK("out pair", oexp[i], pair)
      end
      pair = {ch_pin_out[1], ch_n_out[1]};
      `CHK("ch2 pair", 2'b01, pair)
      // Compare: set active when count reaches three
      wr(`GPT_A_CHCFG, 32'h2000);
      wr(`GPT_A_CCR1, 32'h3);
      wr(`GPT_A_SMC, 32'h7);
      wr(`GPT_A_EVG, 32'h1);
      wr(`GPT_A_CHCFG, 32'h0800);
      wr(`GPT_A_STAT, 32'h1F);
      wr(`GPT_A_CTRL, 32'h1);
      far.trig_pulses(0, 2);
      repeat (16) @(posedge mclk);
      `CHK("before match", 1'b0, ch_pin_out[0])
      far.trig_pulses(0, 1);
      repeat (16) @(posedge mclk);
      `CHK("after match", 1'b1, ch_pin_out[0])
      rd_chk("match flag", `GPT_A_STAT, 32'h1);
      // Forced low: the match still raises the flag
      wr(`GPT_A_CHCFG, 32'h2000);
      wr(`GPT_A_EVG, 32'h1);
      wr(`GPT_A_STAT, 32'h1F);
      far.trig_pulses(0, 3);
      repeat (16) @(posedge mclk);
      `CHK("forced out", 1'b0, ch_pin_out[0])
      rd_chk("forced flag", `GPT_A_STAT, 32'h1);
      report_and_stop();
   end
endmodule // tb
